//--- inc/acc_pkg.sv
package acc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register indexes on the plain port
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_PIN_BUF_OFF = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
  // Control/status and pin buffer-off field positions
  localparam int BIT_POWER_OFF = 7;
  localparam int BIT_BANDGAP = 6;
  localparam int BIT_RESULT = 5;
  localparam int BIT_IRQ_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_CAPTURE = 2;
  localparam int BIT_MODE_HI = 1;
  localparam int BIT_MODE_LO = 0;
  localparam int BIT_NEG_BUF_OFF = 1;
  localparam int BIT_POS_BUF_OFF = 0;
  // Event status bits: 0 comparator event, 1 rising, 2 falling
  localparam int EVT_N = 3;
  localparam int EVT_MATCH = 0;
  localparam int EVT_RISE = 1;
  localparam int EVT_FALL = 2;
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [EVT_N-1:0] EVT_ZERO = 3'h0;
endpackage : acc_pkg

//--- src/acc_comparator_ctrl.sv
// Summary of operation
// R1: Result is one when selected positive input exceeds negative pin.
// R2: Power-off bit removes comparator power; settable any time.
// R3: Bandgap-select feeds internal reference, else positive pin.
// R4: Result status bit is synchronised copy, lagging one to two cycles.
// R5: Flag set when output event matches selected mode.
// R6: Flag cleared on vector acknowledge or writing one to it.
// R7: Interrupt requested only with enable bit and global enable; o_irq needs neither, only evt_stat_reg and evt_en_reg.
// R8: Capture-route bit connects result to timer capture, else none.
// R9: Mode field: 00 toggle, 01 reserved, 10 falling, 11 rising.
// R10: Software disables interrupt before changing power-off or mode.
// R11: Buffer-off bits disable pin buffers; port bits read zero.
// R12: Events detected on synchronised result by consecutive samples.
module acc_comparator_ctrl
  import acc_pkg::*;
(
  input wire logic i_clk, // System clock 100 MHz
  input wire logic i_resetn, // Sync reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic [ADDR_W-1:0] i_addr, // Register address
  input wire logic [DATA_W-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic i_cmp_raw, // Raw analog comparator output
  input wire logic i_global_irq_en, // CPU global interrupt enable
  input wire logic i_vector_ack, // Comparator vector executed
  input wire logic i_pos_pin_digital, // Positive pin digital buffer value
  input wire logic i_neg_pin_digital, // Negative pin digital buffer value
  output logic [DATA_W-1:0] o_rdata, // Read data, cycle after strobe
  output logic o_cmp_power_off, // Comparator power switch off
  output logic o_bandgap_select, // Positive input from bandgap
  output logic o_capture_in, // Timer capture front-end input
  output logic o_capture_sel, // Capture source is comparator
  output logic o_pos_buf_off, // Positive pin buffer disable
  output logic o_neg_buf_off, // Negative pin buffer disable
  output logic o_pos_pin_read, // Port bit seen by software
  output logic o_neg_pin_read, // Port bit seen by software
  output logic o_cmp_irq_req, // Comparator vector request
  output logic o_irq // Event summary interrupt
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic power_off_reg;
  logic bandgap_reg;
  logic flag_reg;
  logic irq_en_reg;
  logic capture_reg;
  logic [1:0] mode_reg;
  logic [1:0] buf_off_reg;
  logic [EVT_N-1:0] evt_stat_reg;
  logic [EVT_N-1:0] evt_en_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rise;
  logic fall;
  logic match;
  logic wr_ctrl;
  logic [EVT_N-1:0] evt_hit;
  logic [EVT_N-1:0] evt_clr;

  assign wr_ctrl = i_wr && (i_addr == ADDR_CTRL_STATUS);

  // R4 two-stage synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (i_ce) begin
      sync1_reg <= i_cmp_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // R12 edges from consecutive samples
  assign rise = sync2_reg && !prev_reg;
  assign fall = !sync2_reg && prev_reg;

  // R9 mode decode; reserved mode never fires
  always_comb begin
    case (mode_reg)
      MODE_TOGGLE: match = rise || fall;
      MODE_FALL: match = fall;
      MODE_RISE: match = rise;
      default: match = 1'b0;
    endcase
  end

  // R2 R3 R7 R8 control fields
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      power_off_reg <= 1'b0;
      bandgap_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      capture_reg <= 1'b0;
      mode_reg <= MODE_TOGGLE;
    end else if (i_ce && wr_ctrl) begin
      power_off_reg <= i_wdata[BIT_POWER_OFF];
      bandgap_reg <= i_wdata[BIT_BANDGAP];
      irq_en_reg <= i_wdata[BIT_IRQ_EN];
      capture_reg <= i_wdata[BIT_CAPTURE];
      mode_reg <= {i_wdata[BIT_MODE_HI], i_wdata[BIT_MODE_LO]};
    end
  end

  // R5 R6 flag; a new event wins over a clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      flag_reg <= 1'b0;
    end else if (i_ce) begin
      if (match) begin
        flag_reg <= 1'b1;
      end else if (i_vector_ack || (wr_ctrl && i_wdata[BIT_IRQ_FLAG])) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // R11 pin buffer disables
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      buf_off_reg <= 2'h0;
    end else if (i_ce && i_wr && (i_addr == ADDR_PIN_BUF_OFF)) begin
      buf_off_reg <= {i_wdata[BIT_NEG_BUF_OFF], i_wdata[BIT_POS_BUF_OFF]};
    end
  end

  assign evt_hit = {fall, rise, match};
  assign evt_clr = (i_wr && (i_addr == ADDR_IRQ_CLEAR)) ? i_wdata[EVT_N-1:0] : EVT_ZERO;

  // Sticky event status, set beats clear
  genvar g;
  generate
    for (g = 0; g < EVT_N; g++) begin : g_evt
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          evt_stat_reg[g] <= 1'b0;
        end else if (i_ce) begin
          if (evt_hit[g]) begin
            evt_stat_reg[g] <= 1'b1;
          end else if (evt_clr[g]) begin
            evt_stat_reg[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      evt_en_reg <= EVT_ZERO;
    end else if (i_ce && i_wr && (i_addr == ADDR_IRQ_ENABLE)) begin
      evt_en_reg <= i_wdata[EVT_N-1:0];
    end
  end

  always_comb begin
    rdata_next = RESET_VAL;
    case (i_addr)
      ADDR_CTRL_STATUS: begin
        rdata_next[BIT_POWER_OFF] = power_off_reg;
        rdata_next[BIT_BANDGAP] = bandgap_reg;
        rdata_next[BIT_RESULT] = sync2_reg;
        rdata_next[BIT_IRQ_FLAG] = flag_reg;
        rdata_next[BIT_IRQ_EN] = irq_en_reg;
        rdata_next[BIT_CAPTURE] = capture_reg;
        rdata_next[BIT_MODE_HI] = mode_reg[1];
        rdata_next[BIT_MODE_LO] = mode_reg[0];
      end
      ADDR_PIN_BUF_OFF: begin
        rdata_next[BIT_NEG_BUF_OFF] = buf_off_reg[1];
        rdata_next[BIT_POS_BUF_OFF] = buf_off_reg[0];
      end
      ADDR_IRQ_STATUS: rdata_next[EVT_N-1:0] = evt_stat_reg;
      ADDR_IRQ_ENABLE: rdata_next[EVT_N-1:0] = evt_en_reg;
      default: rdata_next = RESET_VAL;
    endcase
  end

  // Registered outputs
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= RESET_VAL;
      o_cmp_power_off <= 1'b0;
      o_bandgap_select <= 1'b0;
      o_capture_in <= 1'b0;
      o_capture_sel <= 1'b0;
      o_pos_buf_off <= 1'b0;
      o_neg_buf_off <= 1'b0;
      o_pos_pin_read <= 1'b0;
      o_neg_pin_read <= 1'b0;
      o_cmp_irq_req <= 1'b0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_rdata <= i_rd ? rdata_next : RESET_VAL;
      // R2 power switch
      o_cmp_power_off <= power_off_reg;
      // R1 R3 input mux steering in the analog core
      o_bandgap_select <= bandgap_reg;
      // R8 capture route, low when unrouted
      o_capture_in <= capture_reg && sync2_reg;
      o_capture_sel <= capture_reg;
      // R11 buffers off force zero reads
      o_pos_buf_off <= buf_off_reg[0];
      o_neg_buf_off <= buf_off_reg[1];
      o_pos_pin_read <= i_pos_pin_digital && !buf_off_reg[0];
      o_neg_pin_read <= i_neg_pin_digital && !buf_off_reg[1];
      // R7 gated vector request
      o_cmp_irq_req <= flag_reg && irq_en_reg && i_global_irq_en && !i_vector_ack;
      o_irq <= |(evt_stat_reg & evt_en_reg);
    end
  end

  // R4 status lags raw by two samples
  result_lag_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
    (i_ce && $past(i_ce) && $past(i_ce, 2)) |-> (sync2_reg == $past(i_cmp_raw, 2)))
    else $error("Result status not a two-cycle copy");

  // R5 matching event sets flag
  flag_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R5
    (i_ce && match) |=> flag_reg)
    else $error("Flag not set on event");

  // R6 clear on acknowledge
  flag_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
    (i_ce && !match && i_vector_ack) |=> !flag_reg)
    else $error("Flag not cleared on acknowledge");

  // R7 request needs enable
  req_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R7
    (i_ce && !irq_en_reg) |=> !o_cmp_irq_req)
    else $error("Request without enable");

  // R9 reserved mode silent
  mode_rsvd_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
    (mode_reg == MODE_RSVD) |-> !match)
    else $error("Reserved mode fired");

  // R9 rising mode ignores fall
  mode_rise_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
    (mode_reg == MODE_RISE && fall) |-> !match)
    else $error("Rising mode fired on fall");

  // R8 unrouted capture stays low
  capture_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R8
    (i_ce && !capture_reg) |=> !o_capture_in)
    else $error("Capture driven while unrouted");

  // R11 disabled buffer reads zero
  buf_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
    (i_ce && buf_off_reg[0]) |=> !o_pos_pin_read)
    else $error("Disabled pin read nonzero");

  // R2 power bit follows write
  power_wr_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
    (i_ce && wr_ctrl) |=> (power_off_reg == $past(i_wdata[BIT_POWER_OFF])))
    else $error("Power-off bit not written");

  // R4 first stage samples raw
  sync_first_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
    i_ce |=> (sync1_reg == $past(i_cmp_raw)))
    else $error("First sync stage missed raw");

  // R12 previous sample kept
  prev_copy_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R12
    i_ce |=> (prev_reg == $past(sync2_reg)))
    else $error("Previous sample not kept");

  // R12 change yields an edge
  edge_seen_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R12
    (i_ce && (sync1_reg != sync2_reg)) |=> (rise || fall))
    else $error("Result change gave no edge");

  // R9 toggle mode fires both ways
  mode_toggle_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
    (mode_reg == MODE_TOGGLE && (rise || fall)) |-> match)
    else $error("Toggle mode missed an edge");

  // R9 falling mode fires on fall
  mode_fall_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
    (mode_reg == MODE_FALL && fall) |-> match)
    else $error("Falling mode missed a fall");

  // R9 falling mode ignores rise
  fall_ignores_rise_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
    (mode_reg == MODE_FALL && rise) |-> !match)
    else $error("Falling mode fired on rise");

  // R9 rising mode fires on rise
  mode_rise_hit_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
    (mode_reg == MODE_RISE && rise) |-> match)
    else $error("Rising mode missed a rise");

  // R6 software clear
  flag_sw_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
    (i_ce && !match && wr_ctrl && i_wdata[BIT_IRQ_FLAG]) |=> !flag_reg)
    else $error("Flag not cleared by write");

  // R5 no flag without event
  flag_no_spur_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R5
    (i_ce && !match && !flag_reg) |=> !flag_reg)
    else $error("Flag set without event");

  // R7 request raised when allowed
  req_on_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R7
    (i_ce && flag_reg && irq_en_reg && i_global_irq_en && !i_vector_ack) |=> o_cmp_irq_req)
    else $error("Request missing");

  // R7 global enable gates request
  req_global_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R7
    (i_ce && !i_global_irq_en) |=> !o_cmp_irq_req)
    else $error("Request without global enable");

  // R8 routed capture follows result
  capture_on_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R8
    (i_ce && capture_reg) |=> (o_capture_in == $past(sync2_reg)))
    else $error("Capture not following result");

  // R3 reference select output
  bandgap_out_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
    i_ce |=> (o_bandgap_select == $past(bandgap_reg)))
    else $error("Reference select not driven");

  // R2 power switch output
  power_out_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
    i_ce |=> (o_cmp_power_off == $past(power_off_reg)))
    else $error("Power switch not driven");

  // R11 negative pin reads zero
  neg_buf_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
    (i_ce && buf_off_reg[1]) |=> !o_neg_pin_read)
    else $error("Disabled negative pin read nonzero");

  // R11 enabled buffer passes pin
  pos_pin_pass_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
    (i_ce && !buf_off_reg[0]) |=> (o_pos_pin_read == $past(i_pos_pin_digital)))
    else $error("Enabled pin not passed");

  // Clock enable low holds state
  ce_freeze_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!i_ce) |=> ($stable(flag_reg) && $stable(sync2_reg) && $stable(o_rdata)))
    else $error("State moved while frozen");

  // Read data only after a strobe
  rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && !i_rd) |=> (o_rdata == RESET_VAL))
    else $error("Read data without strobe");
endmodule : acc_comparator_ctrl

//--- bench/acc_cmp_model.sv
module acc_cmp_model #(
  parameter int BANDGAP_MV = 1100 // Plain default reference level
) (
  input wire logic i_power_off, // Comparator power switch
  input wire logic i_bandgap, // Positive input from reference
  input var int i_pos_mv, // Positive pin level in mV
  input var int i_neg_mv, // Negative pin level in mV
  output logic o_raw // Raw compare result
);
  timeunit 1ns;
  timeprecision 1ns;
  // compare selected input
  // Unpowered core is held low, not left floating
  always_comb o_raw = !i_power_off && ((i_bandgap ? BANDGAP_MV : i_pos_mv) > i_neg_mv);
endmodule : acc_cmp_model

//--- bench/test_acc_comparator_ctrl.sv
module test_acc_comparator_ctrl
  import acc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ce = 1'b1;
  logic i_global_irq_en = 1'b0;
  logic i_vector_ack = 1'b0;
  logic i_pos_pin_digital = 1'b0;
  logic i_neg_pin_digital = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic [DATA_W-1:0] o_rdata;
  logic i_cmp_raw, o_cmp_power_off, o_bandgap_select, o_capture_in, o_capture_sel;
  logic o_pos_buf_off, o_neg_buf_off, o_pos_pin_read, o_neg_pin_read, o_cmp_irq_req, o_irq;
  int pos_mv = 0;
  int neg_mv = 500;
  int fails = 0;
  int checks = 0;
  logic [1:0] modes [3] = '{MODE_TOGGLE, MODE_FALL, MODE_RISE};
  logic [1:0] flags [3] = '{2'h3, 2'h1, 2'h2};
  always #5 i_clk = ~i_clk;
  acc_comparator_ctrl u_dut (.i_clk, .i_resetn, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_cmp_raw, .i_global_irq_en, .i_vector_ack, .i_pos_pin_digital, .i_neg_pin_digital,
    .o_rdata, .o_cmp_power_off, .o_bandgap_select, .o_capture_in, .o_capture_sel,
    .o_pos_buf_off, .o_neg_buf_off, .o_pos_pin_read, .o_neg_pin_read, .o_cmp_irq_req, .o_irq);
  acc_cmp_model u_cmp (.i_power_off(o_cmp_power_off), .i_bandgap(o_bandgap_select),
    .i_pos_mv(pos_mv), .i_neg_mv(neg_mv), .o_raw(i_cmp_raw));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd
  // Registered outputs lag the register by one cycle
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic set_in(input int p);
    @(posedge i_clk);
    pos_mv <= p;
    settle(6);
  endtask : set_in
  task automatic t_regs;
    rd(ADDR_CTRL_STATUS, RESET_VAL);
    rd(ADDR_PIN_BUF_OFF, RESET_VAL);
    rd(ADDR_IRQ_ENABLE, RESET_VAL);
    wr(ADDR_IRQ_STATUS, 8'h07);
    rd(ADDR_IRQ_STATUS, 8'h00);
    rd(4'hf, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ctrl;
    wr(ADDR_CTRL_STATUS, 8'hc4);
    settle(2);
    chk({5'h0, o_cmp_power_off, o_bandgap_select, o_capture_sel}, 8'h07);
    rd(ADDR_CTRL_STATUS, 8'hc4);
    wr(ADDR_CTRL_STATUS, 8'h41);
    settle(4);
    rd(ADDR_CTRL_STATUS, 8'h61);
    wr(ADDR_CTRL_STATUS, 8'h01);
    settle(4);
    rd(ADDR_CTRL_STATUS, 8'h01);
    wr(ADDR_CTRL_STATUS, 8'h05);
    @(posedge i_clk);
    pos_mv <= 2000;
    settle(1);
    chk({7'h0, o_capture_in}, 8'h00);
    settle(4);
    chk({6'h0, o_capture_sel, o_capture_in}, 8'h03);
    wr(ADDR_CTRL_STATUS, 8'h01);
    set_in(0);
    chk({6'h0, o_capture_sel, o_capture_in}, 8'h00);
    $display("test ctrl done");
  endtask : t_ctrl
  task automatic t_modes;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL_STATUS, {6'h04, modes[i]});
      set_in(2000);
      rd(ADDR_CTRL_STATUS, {2'h0, 1'b1, flags[i][1], 2'h0, modes[i]});
      wr(ADDR_CTRL_STATUS, {6'h04, modes[i]});
      set_in(0);
      rd(ADDR_CTRL_STATUS, {3'h0, flags[i][0], 2'h0, modes[i]});
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_irq;
    wr(ADDR_CTRL_STATUS, 8'h13);
    wr(ADDR_IRQ_CLEAR, 8'h07);
    set_in(2000);
    wr(ADDR_CTRL_STATUS, 8'h0b);
    settle(2);
    chk({6'h0, o_cmp_irq_req, o_irq}, 8'h00);
    @(posedge i_clk);
    i_global_irq_en <= 1'b1;
    settle(2);
    chk({7'h0, o_cmp_irq_req}, 8'h01);
    wr(ADDR_CTRL_STATUS, 8'h03);
    settle(2);
    chk({7'h0, o_cmp_irq_req}, 8'h00);
    wr(ADDR_CTRL_STATUS, 8'h0b);
    rd(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_IRQ_ENABLE, 8'h02);
    settle(2);
    chk({6'h0, o_cmp_irq_req, o_irq}, 8'h03);
    @(posedge i_clk);
    i_vector_ack <= 1'b1;
    @(posedge i_clk);
    i_vector_ack <= 1'b0;
    settle(2);
    chk({7'h0, o_cmp_irq_req}, 8'h00);
    rd(ADDR_CTRL_STATUS, 8'h2b);
    wr(ADDR_IRQ_CLEAR, 8'h02);
    settle(2);
    chk({7'h0, o_irq}, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h01);
    rd(ADDR_IRQ_ENABLE, 8'h02);
    $display("test irq done");
  endtask : t_irq
  task automatic t_pins;
    @(posedge i_clk);
    i_pos_pin_digital <= 1'b1;
    i_neg_pin_digital <= 1'b1;
    wr(ADDR_PIN_BUF_OFF, 8'h03);
    settle(2);
    chk({4'h0, o_pos_buf_off, o_neg_buf_off, o_pos_pin_read, o_neg_pin_read}, 8'h0c);
    rd(ADDR_PIN_BUF_OFF, 8'h03);
    wr(ADDR_PIN_BUF_OFF, 8'h00);
    settle(2);
    chk({4'h0, o_pos_buf_off, o_neg_buf_off, o_pos_pin_read, o_neg_pin_read}, 8'h03);
    $display("test pins done");
  endtask : t_pins
  // Frozen block must drop writes and reads, and pick up input changes once enabled
  task automatic t_ce;
    wr(ADDR_CTRL_STATUS, 8'h03);
    wr(ADDR_CTRL_STATUS, 8'h10);
    @(posedge i_clk);
    i_ce <= 1'b0;
    pos_mv <= 0;
    wr(ADDR_CTRL_STATUS, 8'h40);
    rd(ADDR_CTRL_STATUS, 8'h00); // Frozen read answers nothing
    repeat (4) @(posedge i_clk);
    i_ce <= 1'b1;
    settle(6);
    rd(ADDR_CTRL_STATUS, 8'h10);
    $display("test ce done");
  endtask : t_ce
  task automatic stop_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_regs();
    t_ctrl();
    t_modes();
    t_irq();
    t_pins();
    t_ce();
    stop_test();
  end
  // Tests need about 200 cycles
  initial begin
    #100000;
    fails++;
    stop_test();
  end
endmodule : test_acc_comparator_ctrl
